// ===== logic/atd_defines.svh
`ifndef ATD_DEFINES_SVH
`define ATD_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address = index * 4
// ----------------------------------------
`define ATD_IDX_GAIN_A 10'h07a
`define ATD_IDX_GAIN_B 10'h07b
`define ATD_IDX_REF 10'h07c
`define ATD_IDX_TERM_A 10'h07e
`define ATD_IDX_TERM_B 10'h07f
`define ATD_IDX_NOISE 10'h09d

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATD_NOISE_ON_BIT 0
`define ATD_NOISE_LEVEL_BIT 1
`define ATD_ROUND_TARGET_BIT 2
`define ATD_REF_TRIM_MSB 3
`define ATD_REF_RSVD_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATD_NOISE_RESET 8'h01
`define ATD_REF_RSVD_RESET 4'h0
`define ATD_PRE_LOAD 8'h00
`define ATD_RDATA_RESET 32'h0000_0000

`endif

// ===== logic/atd_pkg.sv
package atd_pkg;

	// ----------------------------------------
	// Sequencer states, Gray coded
	// ----------------------------------------
	typedef enum logic [0:0] {
		ATD_ST_LOAD = 1'h0,
		ATD_ST_RUN = 1'h1
	} atd_state_t;

	// ----------------------------------------
	// Factory trim values from fuse storage
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] gain_a;
		logic [7:0] gain_b;
		logic [3:0] ref_trim;
		logic [7:0] term_a;
		logic [7:0] term_b;
	} atd_fuse_t;

	// ----------------------------------------
	// Controls to the analog circuitry
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] gain_adjust_chan_a;
		logic [7:0] gain_adjust_chan_b;
		logic [3:0] reference_voltage_adjust;
		logic [7:0] termination_adjust_chan_a;
		logic [7:0] termination_adjust_chan_b;
		logic noise_injection_on;
		logic noise_injection_level;
		logic rounding_error_target;
	} atd_ctrl_t;

	// ----------------------------------------
	// Register bank contents
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] gain_a;
		logic [7:0] gain_b;
		logic [7:0] ref_adj;
		logic [7:0] term_a;
		logic [7:0] term_b;
		logic [7:0] noise;
	} atd_regs_t;

	// ----------------------------------------
	// Whole module state
	// ----------------------------------------
	typedef struct packed {
		atd_state_t st;
		atd_regs_t regs;
		logic [31:0] prdata;
		logic pslverr;
		logic acc;
	} atd_all_t;

endpackage

// ===== logic/atd_trim_regs.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "atd_defines.svh"

// What this block does
// - After reset each trim register loads fuse values; stays readable and writable
// - Eight-bit read-write gain trim for channel A drives its gain
// - Eight-bit read-write gain trim for channel B drives its gain
// - Reference trim in bits 3-0; bits 7-4 reserved read-write, reset zero
// - Eight-bit read-write termination trim for channel A
// - Eight-bit read-write termination trim for channel B
// - Noise control bit 0 enables dither, resets to one
// - Noise control bit 1 picks dither amplitude, zero small, resets zero
// - Noise control bit 2 picks where rounding error goes, resets zero
// - Noise control resets to 0x01; bits 7-3 reserved read-write zero
module atd_trim_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Fuse storage
	input wire atd_pkg::atd_fuse_t fuse_in,
	// Analog controls
	output atd_pkg::atd_ctrl_t ctrl_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	atd_pkg::atd_all_t q;
	atd_pkg::atd_all_t d;
	logic hit;
	logic [7:0] rd_val;
	logic wr_fire;

	// ----------------------------------------
	// Handshake
	// ----------------------------------------
	assign pready = penable & q.acc;
	assign wr_fire = psel & pready & pwrite & pstrb[0];
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		hit = 1'h1;
		rd_val = `ATD_PRE_LOAD;
		if (paddr == {`ATD_IDX_GAIN_A, 2'h0}) begin
			rd_val = q.regs.gain_a;
		end else if (paddr == {`ATD_IDX_GAIN_B, 2'h0}) begin
			rd_val = q.regs.gain_b;
		end else if (paddr == {`ATD_IDX_REF, 2'h0}) begin
			rd_val = q.regs.ref_adj;
		end else if (paddr == {`ATD_IDX_TERM_A, 2'h0}) begin
			rd_val = q.regs.term_a;
		end else if (paddr == {`ATD_IDX_TERM_B, 2'h0}) begin
			rd_val = q.regs.term_b;
		end else if (paddr == {`ATD_IDX_NOISE, 2'h0}) begin
			rd_val = q.regs.noise;
		end else begin
			hit = 1'h0;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.acc = psel & (q.st == atd_pkg::ATD_ST_RUN) & ~pready;
		// Capture read data ahead of the answer
		if (psel && !pready) begin
			d.prdata = {24'h00_0000, rd_val};
			d.pslverr = ~hit;
		end
		case (q.st)
			atd_pkg::ATD_ST_LOAD: begin
				// Factory values once after reset
				d.regs.gain_a = fuse_in.gain_a;
				d.regs.gain_b = fuse_in.gain_b;
				d.regs.ref_adj = {`ATD_REF_RSVD_RESET,
					fuse_in.ref_trim};
				d.regs.term_a = fuse_in.term_a;
				d.regs.term_b = fuse_in.term_b;
				d.st = atd_pkg::ATD_ST_RUN;
			end
			atd_pkg::ATD_ST_RUN: begin
				if (wr_fire && hit) begin
					if (paddr == {`ATD_IDX_GAIN_A, 2'h0}) begin
						d.regs.gain_a = pwdata[7:0];
					end else if (paddr == {`ATD_IDX_GAIN_B, 2'h0}) begin
						d.regs.gain_b = pwdata[7:0];
					end else if (paddr == {`ATD_IDX_REF, 2'h0}) begin
						d.regs.ref_adj = pwdata[7:0];
					end else if (paddr == {`ATD_IDX_TERM_A, 2'h0}) begin
						d.regs.term_a = pwdata[7:0];
					end else if (paddr == {`ATD_IDX_TERM_B, 2'h0}) begin
						d.regs.term_b = pwdata[7:0];
					end else begin
						d.regs.noise = pwdata[7:0];
					end
				end
			end
			default: begin
				d.st = atd_pkg::ATD_ST_LOAD;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q.st <= atd_pkg::ATD_ST_LOAD;
			q.regs.gain_a <= `ATD_PRE_LOAD;
			q.regs.gain_b <= `ATD_PRE_LOAD;
			q.regs.ref_adj <= `ATD_PRE_LOAD;
			q.regs.term_a <= `ATD_PRE_LOAD;
			q.regs.term_b <= `ATD_PRE_LOAD;
			q.regs.noise <= `ATD_NOISE_RESET;
			q.prdata <= `ATD_RDATA_RESET;
			q.pslverr <= 1'h0;
			q.acc <= 1'h0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Analog controls
	// ----------------------------------------
	always_comb begin
		ctrl_out.gain_adjust_chan_a = q.regs.gain_a;
		ctrl_out.gain_adjust_chan_b = q.regs.gain_b;
		ctrl_out.reference_voltage_adjust =
			q.regs.ref_adj[`ATD_REF_TRIM_MSB:0];
		ctrl_out.termination_adjust_chan_a = q.regs.term_a;
		ctrl_out.termination_adjust_chan_b = q.regs.term_b;
		ctrl_out.noise_injection_on =
			q.regs.noise[`ATD_NOISE_ON_BIT];
		ctrl_out.noise_injection_level =
			q.regs.noise[`ATD_NOISE_LEVEL_BIT];
		ctrl_out.rounding_error_target =
			q.regs.noise[`ATD_ROUND_TARGET_BIT];
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence s_load;
		q.st == atd_pkg::ATD_ST_LOAD;
	endsequence

	sequence s_write(logic [9:0] idx);
		wr_fire && (paddr == {idx, 2'h0});
	endsequence

	sequence s_read_setup;
		psel && !penable && !pwrite && (q.st == atd_pkg::ATD_ST_RUN);
	endsequence

	property p_fuse_load;
		s_load |=> (ctrl_out.gain_adjust_chan_a == $past(fuse_in.gain_a))
			&& (ctrl_out.termination_adjust_chan_b ==
			$past(fuse_in.term_b))
			&& (q.st == atd_pkg::ATD_ST_RUN);
	endproperty
	a_fuse_load: assert property (p_fuse_load)
		else $error("Fuse values not loaded after reset");

	property p_gain_a;
		s_write(`ATD_IDX_GAIN_A) |=>
			ctrl_out.gain_adjust_chan_a == $past(pwdata[7:0]);
	endproperty
	a_gain_a: assert property (p_gain_a)
		else $error("Gain A write not applied");

	property p_gain_b;
		s_write(`ATD_IDX_GAIN_B) |=>
			ctrl_out.gain_adjust_chan_b == $past(pwdata[7:0]);
	endproperty
	a_gain_b: assert property (p_gain_b)
		else $error("Gain B write not applied");

	property p_ref;
		s_load |=> q.regs.ref_adj[7:`ATD_REF_RSVD_LSB] == 4'h0
			and ctrl_out.reference_voltage_adjust ==
			$past(fuse_in.ref_trim);
	endproperty
	a_ref: assert property (p_ref)
		else $error("Reference trim load wrong");

	property p_term;
		s_write(`ATD_IDX_TERM_A) |=>
			ctrl_out.termination_adjust_chan_a == $past(pwdata[7:0])
			&& $stable(ctrl_out.termination_adjust_chan_b);
	endproperty
	a_term: assert property (p_term)
		else $error("Termination A write not applied");

	property p_term_b;
		s_write(`ATD_IDX_TERM_B) |=>
			ctrl_out.termination_adjust_chan_b == $past(pwdata[7:0]);
	endproperty
	a_term_b: assert property (p_term_b)
		else $error("Termination B write not applied");

	property p_noise_on;
		s_load |-> ctrl_out.noise_injection_on;
	endproperty
	a_noise_on: assert property (p_noise_on)
		else $error("Dither not enabled after reset");

	property p_level;
		s_write(`ATD_IDX_NOISE) |=>
			ctrl_out.noise_injection_level == $past(pwdata[1])
			&& ctrl_out.rounding_error_target == $past(pwdata[2]);
	endproperty
	a_level: assert property (p_level)
		else $error("Dither level or rounding not applied");

	property p_round_reset;
		s_load |-> !ctrl_out.rounding_error_target
			&& !ctrl_out.noise_injection_level;
	endproperty
	a_round_reset: assert property (p_round_reset)
		else $error("Dither mode bits not reset to zero");

	property p_noise_reset;
		s_load |-> q.regs.noise == `ATD_NOISE_RESET;
	endproperty
	a_noise_reset: assert property (p_noise_reset)
		else $error("Noise control reset value wrong");

	property p_read_back;
		s_read_setup ##1 (psel && penable) |->
			pready && prdata == {24'h00_0000, $past(rd_val)}
			&& pslverr == !$past(hit);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("Read data or answer timing wrong");

	property p_no_stall;
		(psel && !penable && q.st == atd_pkg::ATD_ST_RUN) ##1 penable
			|-> pready;
	endproperty
	a_no_stall: assert property (p_no_stall)
		else $error("Access phase stalled in run state");

	sequence s_access;
		psel && penable && pready;
	endsequence

	sequence s_load_setup;
		psel && !penable && (q.st == atd_pkg::ATD_ST_LOAD);
	endsequence

	property p_ref_write;
		s_write(`ATD_IDX_REF) |=>
			q.regs.ref_adj == $past(pwdata[7:0])
			&& ctrl_out.reference_voltage_adjust ==
			$past(pwdata[3:0]);
	endproperty
	a_ref_write: assert property (p_ref_write)
		else $error("Reference trim write not applied");

	property p_noise_store;
		s_write(`ATD_IDX_NOISE) |=>
			q.regs.noise == $past(pwdata[7:0])
			&& ctrl_out.noise_injection_on == $past(pwdata[0]);
	endproperty
	a_noise_store: assert property (p_noise_store)
		else $error("Noise control write not stored");

	property p_unmapped;
		s_access ##0 (!hit) |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("Unmapped access not flagged");

	property p_hold;
		!(wr_fire && hit) && (q.st == atd_pkg::ATD_ST_RUN) |=>
			$stable(q.regs);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Register changed without a write");

	property p_wait_load;
		s_load_setup ##1 penable |-> !pready;
	endproperty
	a_wait_load: assert property (p_wait_load)
		else $error("No wait state for access in load cycle");

endmodule

// ===== sim/adc_trim_dither_registers_tb.sv
`timescale 1ns/1ps
module adc_trim_dither_registers_tb;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	atd_pkg::atd_fuse_t fuse_in = 36'h0_0000_0000;
	atd_pkg::atd_ctrl_t ctrl_out;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] m [6];
	logic [11:0] adr [6] = '{12'h1e8, 12'h1ec, 12'h1f0, 12'h1f8, 12'h1fc,
		12'h274};

	atd_trim_regs dut (
		.clock(clock),
		.nrst(nrst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.fuse_in(fuse_in),
		.ctrl_out(ctrl_out)
	);

	initial begin
		forever #2.5 clock = ~clock;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [38:0] got,
		input logic [38:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		pstrb <= s;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 64);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			fail_count++;
			summarize();
		end
	endtask

	function automatic atd_pkg::atd_ctrl_t cexp();
		return {m[0], m[1], m[2][3:0], m[3], m[4], m[5][0], m[5][1],
			m[5][2]};
	endfunction

	task automatic wr(input int i, input logic [7:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'h1, adr[i], d, 4'hf, rd, e);
		m[i] = d;
		@(negedge clock);
		chk("ctrl after write", ctrl_out, cexp());
	endtask

	task automatic rdchk(input int i);
		logic [31:0] rd;
		logic e;
		apb(1'h0, adr[i], 8'h00, 4'hf, rd, e);
		chk("readback", rd, {24'h00_0000, m[i]});
		chk("read error flag", e, 1'h0);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset(input atd_pkg::atd_fuse_t f);
		@(posedge clock);
		nrst <= 1'h0;
		fuse_in <= f;
		repeat (8) @(posedge clock);
		chk("noise bits in reset", ctrl_out[2:0], 3'h4);
		nrst <= 1'h1;
		m = '{f.gain_a, f.gain_b, {4'h0, f.ref_trim}, f.term_a, f.term_b,
			8'h01};
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("ctrl after reset", ctrl_out, cexp());
		chk("dither on", ctrl_out.noise_injection_on, 1'h1);
		chk("dither small", ctrl_out.noise_injection_level, 1'h0);
		chk("round", ctrl_out.rounding_error_target, 1'h0);
		for (int i = 0; i < 6; i++) begin
			rdchk(i);
		end
	endtask

	task automatic t_rw();
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 6; i++) begin
				wr(i, (p == 0 ? 8'hf0 : 8'h58) ^ 8'(i));
			end
			for (int i = 0; i < 6; i++) begin
				rdchk(i);
			end
		end
		chk("gain a", ctrl_out.gain_adjust_chan_a, 8'h58);
		chk("gain b", ctrl_out.gain_adjust_chan_b, 8'h59);
		chk("ref", ctrl_out.reference_voltage_adjust, 4'ha);
		chk("term a", ctrl_out.termination_adjust_chan_a, 8'h5b);
		chk("term b", ctrl_out.termination_adjust_chan_b, 8'h5c);
	endtask

	task automatic t_noise();
		for (int k = 0; k < 8; k++) begin
			wr(5, {5'h15, 3'(k)});
			chk("dither on", ctrl_out.noise_injection_on, k[0]);
			chk("level", ctrl_out.noise_injection_level, k[1]);
			chk("round", ctrl_out.rounding_error_target, k[2]);
			rdchk(5);
		end
	endtask

	task automatic t_refuse();
		logic [31:0] rd;
		logic e;
		apb(1'h1, 12'h1f4, 8'hff, 4'hf, rd, e);
		chk("unmapped write error", e, 1'h1);
		apb(1'h0, 12'h1f4, 8'h00, 4'hf, rd, e);
		chk("unmapped read", {rd, e}, 33'h0_0000_0001);
		apb(1'h1, adr[0], 8'h77, 4'he, rd, e);
		chk("masked write error", e, 1'h0);
		rdchk(0);
		chk("ctrl after masked write", ctrl_out, cexp());
	endtask

	task automatic t_early(input atd_pkg::atd_fuse_t f);
		logic [31:0] rd;
		logic e;
		@(posedge clock);
		nrst <= 1'h0;
		fuse_in <= f;
		repeat (7) @(posedge clock);
		// Setup lands in the fuse load cycle
		fork
			begin
				@(posedge clock);
				nrst <= 1'h1;
			end
			apb(1'h0, adr[0], 8'h00, 4'hf, rd, e);
		join
		chk("read in load cycle", rd, {24'h00_0000, f.gain_a});
		chk("load cycle read error", e, 1'h0);
	endtask

	initial begin
		t_reset(36'h5_ac39_3ca5);
		t_rw();
		t_noise();
		t_refuse();
		t_early(36'h3_c5a9_0f17);
		t_reset(36'ha_71e6_d24b);
		summarize();
	end
endmodule
